// [core/hwexc_pkg.sv]
package hwexc_pkg;

   //////////////////////////////////////////////////////////////////////////////
   // register map (byte addresses on the apb side)
   localparam logic [11:0] SEQ_STATUS_OFFSET = 12'h000;
   localparam logic [11:0] EXC_RETURN_OFFSET = 12'h004;
   localparam logic [11:0] EXC_CONTROL_OFFSET = 12'h008;

   // sequencer_status field positions
   localparam int EXC_CAUSE_LSB = 0;
   localparam int EXC_CAUSE_W = 6;
   localparam int HW_CAUSE_LSB = 14;
   localparam int HW_CAUSE_W = 5;

   // control register bit positions
   localparam int CTL_SINGLE_STEP_BIT = 0;
   localparam int CTL_TRACE_EXC_EN_BIT = 1;

   // values after reset
   localparam logic [4:0] HW_CAUSE_RESET = 5'h00;
   localparam logic [5:0] EXC_CAUSE_RESET = 6'h00;
   localparam logic [31:0] EXC_RETURN_RESET = 32'h0000_0000;
   localparam logic [1:0] CONTROL_RESET = 2'h0;

   //////////////////////////////////////////////////////////////////////////////
   // hardware error causes
   localparam logic [4:0] HWC_SYS_MMR = 5'h02;
   localparam logic [4:0] HWC_EXT_MEM = 5'h03;
   localparam logic [4:0] HWC_PERF_OVF = 5'h12;
   localparam logic [4:0] HWC_RAISE5 = 5'h18;

   // hardware error source indices; a higher index is the later one on a tie
   localparam int HW_SRC_COUNT = 8;
   localparam int SRC_MMR_INVALID = 0;
   localparam int SRC_MMR_WIDTH = 1;
   localparam int SRC_PERIPHERAL = 2;
   localparam int SRC_BUS_PARITY = 3;
   localparam int SRC_BUS_TIMEOUT = 4;
   localparam int SRC_EXT_MEM = 5;
   localparam int SRC_PERF_OVF = 6;
   localparam int SRC_RAISE5 = 7;

   localparam logic [4:0] HW_SRC_CODE [HW_SRC_COUNT] = '{
      HWC_SYS_MMR, HWC_SYS_MMR, HWC_SYS_MMR, HWC_EXT_MEM,
      HWC_EXT_MEM, HWC_EXT_MEM, HWC_PERF_OVF, HWC_RAISE5
   };

   //////////////////////////////////////////////////////////////////////////////
   // exception causes
   localparam logic [5:0] EXC_SINGLE_STEP = 6'h10;
   localparam logic [5:0] EXC_TRACE_FULL = 6'h11;
   localparam logic [5:0] EXC_UNDEFINED = 6'h21;
   localparam logic [5:0] EXC_ILLEGAL_COMBO = 6'h22;
   localparam logic [5:0] EXC_PROTECTION = 6'h23;

endpackage

// [core/hwexc_err_capture.sv]
`timescale 1ns/10ps

// keeps the code of the newest hardware error and the request level
module hwexc_err_capture #(
   parameter int SOURCES = hwexc_pkg::HW_SRC_COUNT
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // error conditions, one level per source
   input wire logic [SOURCES-1:0] errLevel,
   // captured state
   output logic [4:0] cause,
   output logic request
);

   logic [SOURCES-1:0] prevLevel;
   logic [SOURCES-1:0] rise;
   logic [4:0] next_cause;

   ////////////////////////////////////////////////////////////////////////////////
   // a condition is a new error only on its rising edge
   genvar i;
   generate
      for (i = 0; i < SOURCES; i++) begin : g_rise
         assign rise[i] = errLevel[i] & ~prevLevel[i];
      end
   endgenerate

   // no queue: the highest index that rose this cycle overwrites all others
   always_comb begin
      next_cause = cause;
      for (int k = 0; k < SOURCES; k++) begin
         if (rise[k]) begin
            next_cause = hwexc_pkg::HW_SRC_CODE[k];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         prevLevel <= '0;
      end else begin
         prevLevel <= errLevel;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cause <= hwexc_pkg::HW_CAUSE_RESET;
      end else begin
         cause <= next_cause;
      end
   end

   // held while any condition is still present
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         request <= 1'b0;
      end else begin
         request <= |errLevel;
      end
   end

endmodule

// [core/hwexc_unit.sv]
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/10ps

// Notes on behaviour
// - sequencer status is read-only and readable only in supervisor mode
// - failed external transfers raise the hardware error request
// - each hardware error cause goes into a 5-bit status field
// - sources: bus parity, core internal, peripheral and bus timeout errors
// - only the newest error code is kept; simultaneous errors keep the last
// - error request stays high while any error condition is active
// - invalid or wrong-width system register access reports code 0x02
// - external memory addressing error 0x03, performance overflow 0x12
// - raise to level 5 requests the hardware error with code 0x18
// - no cause code other than the defined ones is ever produced
// - exceptions taken as the instruction finishes; younger ones killed
// - service exceptions commit; return address is the next instruction, or the instruction itself on a double fault
// - error exceptions do not commit; return address is the instruction itself
// - every taken exception writes its code into the 6-bit cause field
// - exception during exception, nmi, reset or emulation is a double fault
// - force-exception instruction is a service exception, cause from 4-bit field
// - single step mode makes every instruction without an error, force or trace exception a 0x10 service exception
// - enabled trace buffer overflow gives a 0x11 service exception
// - undefined instruction is an error exception with code 0x21
// - illegal multi-issue combination is an error exception with code 0x22
// - protection, disallowed data access or dual register access give 0x23
module hwexc_unit #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // processor mode
   input wire logic supervisorMode,
   input wire logic servicingCritical,
   // hardware error conditions
   input wire logic mmrInvalidAccess,
   input wire logic mmrWidthMismatch,
   input wire logic peripheralError,
   input wire logic busParityError,
   input wire logic busTimeoutError,
   input wire logic extMemAddrError,
   input wire logic perfMonOverflow,
   input wire logic raiseLevel5,
   output logic hwErrorRequest,
   // finishing instruction from the pipeline
   input wire logic instrFinishing,
   input wire logic [31:0] instrAddr,
   input wire logic [31:0] instrNextAddr,
   input wire logic forceException,
   input wire logic [3:0] forceExceptionImm,
   input wire logic undefinedInstr,
   input wire logic illegalCombination,
   input wire logic userSupervisorAccess,
   input wire logic dataAccessDisallowed,
   input wire logic dualMmrAccess,
   input wire logic traceBufferOverflow,
   // exception decision
   output logic instrCommit,
   output logic killYounger,
   output logic exceptionTaken,
   output logic exceptionIsError,
   output logic doubleFault,
   output logic [31:0] exceptionReturnAddr
);

   ////////////////////////////////////////////////////////////////////////////////
   // hardware error capture

   logic [hwexc_pkg::HW_SRC_COUNT-1:0] hwLevels;
   logic [4:0] hwCause;
   logic hwRequestRaw;

   always_comb begin
      hwLevels = '0;
      hwLevels[hwexc_pkg::SRC_MMR_INVALID] = mmrInvalidAccess;
      hwLevels[hwexc_pkg::SRC_MMR_WIDTH] = mmrWidthMismatch;
      hwLevels[hwexc_pkg::SRC_PERIPHERAL] = peripheralError;
      hwLevels[hwexc_pkg::SRC_BUS_PARITY] = busParityError;
      hwLevels[hwexc_pkg::SRC_BUS_TIMEOUT] = busTimeoutError;
      hwLevels[hwexc_pkg::SRC_EXT_MEM] = extMemAddrError;
      hwLevels[hwexc_pkg::SRC_PERF_OVF] = perfMonOverflow;
      hwLevels[hwexc_pkg::SRC_RAISE5] = raiseLevel5;
   end

   hwexc_err_capture #(
      .SOURCES(hwexc_pkg::HW_SRC_COUNT)
   ) u_err_capture (
      .clk_sys(clk_sys),
      .reset(reset),
      .errLevel(hwLevels),
      .cause(hwCause),
      .request(hwRequestRaw)
   );

   // the event controller latches this level into its error vector slot
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         hwErrorRequest <= 1'b0;
      end else begin
         hwErrorRequest <= hwRequestRaw | (|hwLevels);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // control register

   logic singleStepMode;
   logic traceExcEnable;
   logic apbWriteDone;
   logic [ADDR_W-1:0] regAddr;
   logic hitStatus;
   logic hitReturn;
   logic hitControl;
   logic accessPhase;

   assign apbWriteDone = psel & penable & pready & pwrite;
   assign regAddr = paddr;

   // address decode; any other word is refused
   assign hitStatus = regAddr == hwexc_pkg::SEQ_STATUS_OFFSET[ADDR_W-1:0];
   assign hitReturn = regAddr == hwexc_pkg::EXC_RETURN_OFFSET[ADDR_W-1:0];
   assign hitControl = regAddr == hwexc_pkg::EXC_CONTROL_OFFSET[ADDR_W-1:0];
   assign accessPhase = psel & penable & ~pready;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         singleStepMode <= hwexc_pkg::CONTROL_RESET[hwexc_pkg::CTL_SINGLE_STEP_BIT];
         traceExcEnable <= hwexc_pkg::CONTROL_RESET[hwexc_pkg::CTL_TRACE_EXC_EN_BIT];
      end else if (apbWriteDone && !pslverr && hitControl) begin
         singleStepMode <= pwdata[hwexc_pkg::CTL_SINGLE_STEP_BIT];
         traceExcEnable <= pwdata[hwexc_pkg::CTL_TRACE_EXC_EN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // trace overflow waits for the next finishing instruction

   logic tracePending;
   logic traceServed;

   // a new overflow in the cycle it is served stays pending
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tracePending <= 1'b0;
      end else if (traceBufferOverflow && traceExcEnable) begin
         tracePending <= 1'b1;
      end else if (traceServed || !traceExcEnable) begin
         tracePending <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pipeline flags count only while their instruction tries to finish
   // one protection code covers three unrelated causes

   logic qUndefined;
   logic qIllegal;
   logic qProtection;
   logic qForce;

   assign qUndefined = instrFinishing & undefinedInstr;
   assign qIllegal = instrFinishing & illegalCombination;
   assign qProtection = instrFinishing &
      (userSupervisorAccess | dataAccessDisallowed | dualMmrAccess);
   assign qForce = instrFinishing & forceException;

   ////////////////////////////////////////////////////////////////////////////////
   // exception selection; error types win because they block the commit

   logic errHit;
   logic svcHit;
   logic [5:0] next_excCause;
   logic [5:0] excCause;

   always_comb begin
      errHit = 1'b1;
      svcHit = 1'b0;
      traceServed = 1'b0;
      next_excCause = excCause;
      if (qUndefined) begin
         next_excCause = hwexc_pkg::EXC_UNDEFINED;
      end else if (qIllegal) begin
         next_excCause = hwexc_pkg::EXC_ILLEGAL_COMBO;
      end else if (qProtection) begin
         next_excCause = hwexc_pkg::EXC_PROTECTION;
      end else begin
         errHit = 1'b0;
         svcHit = 1'b1;
         if (qForce) begin
            next_excCause = {2'h0, forceExceptionImm};
         end else if (tracePending) begin
            next_excCause = hwexc_pkg::EXC_TRACE_FULL;
            traceServed = instrFinishing;
         end else if (singleStepMode) begin
            next_excCause = hwexc_pkg::EXC_SINGLE_STEP;
         end else begin
            svcHit = 1'b0;
         end
      end
   end

   logic takeNow;
   assign takeNow = instrFinishing & (errHit | svcHit);

   // decision pulses one cycle after the finishing strobe
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         exceptionTaken <= 1'b0;
         exceptionIsError <= 1'b0;
         killYounger <= 1'b0;
         instrCommit <= 1'b0;
         doubleFault <= 1'b0;
      end else begin
         exceptionTaken <= takeNow;
         exceptionIsError <= takeNow & errHit;
         killYounger <= takeNow;
         instrCommit <= instrFinishing & ~errHit;
         doubleFault <= takeNow & servicingCritical;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         excCause <= hwexc_pkg::EXC_CAUSE_RESET;
      end else if (takeNow) begin
         excCause <= next_excCause;
      end
   end

   // a double fault always points back at the excepting instruction
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         exceptionReturnAddr <= hwexc_pkg::EXC_RETURN_RESET;
      end else if (takeNow) begin
         if (errHit || servicingCritical) begin
            exceptionReturnAddr <= instrAddr;
         end else begin
            exceptionReturnAddr <= instrNextAddr;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // apb answers: one wait state, pready high for a single cycle

   logic [31:0] seqStatus;
   logic [31:0] next_prdata;
   logic next_pslverr;

   always_comb begin
      seqStatus = '0;
      seqStatus[hwexc_pkg::EXC_CAUSE_LSB +: hwexc_pkg::EXC_CAUSE_W] = excCause;
      seqStatus[hwexc_pkg::HW_CAUSE_LSB +: hwexc_pkg::HW_CAUSE_W] = hwCause;
   end

   always_comb begin
      next_prdata = 32'h0000_0000;
      next_pslverr = 1'b0;
      if (hitStatus) begin
         if (pwrite || !supervisorMode) begin
            next_pslverr = 1'b1;
         end else begin
            next_prdata = seqStatus;
         end
      end else if (hitReturn) begin
         if (pwrite || !supervisorMode) begin
            next_pslverr = 1'b1;
         end else begin
            next_prdata = exceptionReturnAddr;
         end
      end else if (hitControl) begin
         next_prdata[hwexc_pkg::CTL_SINGLE_STEP_BIT] = singleStepMode;
         next_prdata[hwexc_pkg::CTL_TRACE_EXC_EN_BIT] = traceExcEnable;
      end else begin
         next_pslverr = 1'b1;
      end
   end

   typedef enum logic {APB_WAIT, APB_ANSWER} hwexc_apb_state_t;

   hwexc_apb_state_t apbState;
   hwexc_apb_state_t next_apbState;

   // one answer state gives exactly one wait state per access
   always_comb begin
      next_apbState = apbState;
      case (apbState)
         APB_WAIT: begin
            if (accessPhase) begin
               next_apbState = APB_ANSWER;
            end
         end
         APB_ANSWER: begin
            next_apbState = APB_WAIT;
         end
         default: begin
            next_apbState = APB_WAIT;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         apbState <= APB_WAIT;
      end else begin
         apbState <= next_apbState;
      end
   end

   // registered, so pready never follows the master's inputs in the same cycle
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pready <= 1'b0;
      end else begin
         pready <= next_apbState == APB_ANSWER;
      end
   end

   // data and error stand only in the answering cycle
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (accessPhase) begin
         prdata <= pwrite ? 32'h0000_0000 : next_prdata;
         pslverr <= next_pslverr;
      end else begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

endmodule

// [tb/hwexc_err_source.sv]
`timescale 1ns/10ps

// stand-in for the bus controllers and peripherals that flag failed transfers
module hwexc_err_source (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // request from the bench
   input wire logic start,
   input wire logic [7:0] srcMask,
   input wire logic [3:0] holdLen,
   // error levels towards the core
   output logic [7:0] errLevel = 8'h00
);
   logic [3:0] left = 4'h0;

   // a level stays up for the whole failing transfer, then the line idles low
   always @(posedge clk_sys) begin
      if (reset) begin
         errLevel <= 8'h00;
         left <= 4'h0;
      end else if (start) begin
         errLevel <= srcMask;
         left <= holdLen;
      end else if (left > 4'h1) begin
         left <= left - 4'h1;
      end else begin
         errLevel <= 8'h00;
         left <= 4'h0;
      end
   end
endmodule

// [tb/hwexc_monitor.sv]
`timescale 1ns/10ps

module hwexc_monitor #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // mode
   input wire logic supervisorMode,
   input wire logic servicingCritical,
   // hardware errors
   input wire logic mmrInvalidAccess,
   input wire logic mmrWidthMismatch,
   input wire logic peripheralError,
   input wire logic busParityError,
   input wire logic busTimeoutError,
   input wire logic extMemAddrError,
   input wire logic perfMonOverflow,
   input wire logic raiseLevel5,
   input wire logic hwErrorRequest,
   // pipeline
   input wire logic instrFinishing,
   input wire logic [31:0] instrAddr,
   input wire logic [31:0] instrNextAddr,
   input wire logic forceException,
   input wire logic undefinedInstr,
   input wire logic illegalCombination,
   input wire logic userSupervisorAccess,
   input wire logic dataAccessDisallowed,
   input wire logic dualMmrAccess,
   input wire logic instrCommit,
   input wire logic killYounger,
   input wire logic exceptionTaken,
   input wire logic exceptionIsError,
   input wire logic doubleFault,
   input wire logic [31:0] exceptionReturnAddr
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);

   logic anyErr;
   logic errFlag;
   logic apbAccess;
   assign anyErr = mmrInvalidAccess | mmrWidthMismatch | peripheralError | busParityError
      | busTimeoutError | extMemAddrError | perfMonOverflow | raiseLevel5;
   assign errFlag = undefinedInstr | illegalCombination | userSupervisorAccess
      | dataAccessDisallowed | dualMmrAccess;
   assign apbAccess = psel & penable & !pready;

   ////////////////////////////////////////////////////////////////////////////
   a_write_refused: assert property (
      apbAccess && pwrite && paddr == '0 |=> pready && pslverr)
      else $error("status write not refused");
   a_user_read_refused: assert property (
      apbAccess && !pwrite && !supervisorMode && paddr == '0 |=> pready && pslverr)
      else $error("user mode status read not refused");
   a_request_follows: assert property (
      anyErr |=> hwErrorRequest)
      else $error("error request low while an error is active");
   // two trailing cycles are allowed after the last condition drops
   a_request_drops: assert property (
      !anyErr [*3] |-> !hwErrorRequest)
      else $error("error request stuck high");
   a_error_exception: assert property (
      instrFinishing && errFlag |=> exceptionTaken && exceptionIsError && !instrCommit
      && exceptionReturnAddr == $past(instrAddr))
      else $error("error exception decision wrong");
   a_service_exception: assert property (
      instrFinishing && forceException && !errFlag && !servicingCritical |=> exceptionTaken
      && !exceptionIsError && instrCommit && exceptionReturnAddr == $past(instrNextAddr))
      else $error("service exception decision wrong");
   a_double_fault: assert property (
      instrFinishing && servicingCritical && errFlag |=> doubleFault
      && exceptionReturnAddr == $past(instrAddr))
      else $error("double fault not flagged");
   a_no_idle_event: assert property (
      !instrFinishing |=> !exceptionTaken && !instrCommit && !doubleFault)
      else $error("event without a finishing instruction");
   a_kill_younger: assert property (
      killYounger == exceptionTaken)
      else $error("younger instructions not killed with exception");
   a_return_holds: assert property (
      !exceptionTaken |-> $stable(exceptionReturnAddr))
      else $error("return address changed without exception");

   c_error_exc: cover property (exceptionTaken && exceptionIsError);
   c_service_exc: cover property (exceptionTaken && instrCommit);
   c_double: cover property (doubleFault);
   c_request: cover property (hwErrorRequest);
endmodule

bind hwexc_unit hwexc_monitor #(.ADDR_W(ADDR_W)) hwexc_monitor_i (.*);

// [tb/testbench.sv]
`timescale 1ns/10ps

module testbench;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, hwErrorRequest;
   logic supervisorMode = 1'b1, servicingCritical = 1'b0;
   logic start = 1'b0;
   logic [7:0] srcMask = 8'h00, errLevel;
   logic [3:0] holdLen = 4'h1, forceExceptionImm = 4'h0;
   logic instrFinishing = 1'b0, forceException = 1'b0, traceBufferOverflow = 1'b0;
   logic [4:0] instrFlags = 5'h00;
   logic [31:0] instrAddr = 32'h0, instrNextAddr = 32'h0, exceptionReturnAddr;
   logic instrCommit, killYounger, exceptionTaken, exceptionIsError, doubleFault;
   logic [33:0] apbQ[$], excQ[$];
   logic [4:0] expHw = 5'h00;
   logic [5:0] expExc = 6'h00;
   int seed = 84;
   int nFail = 0;
   int nCompared = 0;

   always #25 clk_sys = ~clk_sys;

   hwexc_err_source hwexc_err_source_i (.*);
   hwexc_unit hwexc_unit_i (.*, .mmrInvalidAccess(errLevel[0]), .mmrWidthMismatch(errLevel[1]),
      .peripheralError(errLevel[2]), .busParityError(errLevel[3]),
      .busTimeoutError(errLevel[4]), .extMemAddrError(errLevel[5]),
      .perfMonOverflow(errLevel[6]), .raiseLevel5(errLevel[7]),
      .undefinedInstr(instrFlags[0]), .illegalCombination(instrFlags[1]),
      .userSupervisorAccess(instrFlags[2]), .dataAccessDisallowed(instrFlags[3]),
      .dualMmrAccess(instrFlags[4]));

   ////////////////////////////////////////////////////////////////////////////
   task automatic flag(input logic [33:0] got, input logic [33:0] exp);
      nCompared++;
      if (got !== exp) begin
         nFail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // read data is only compared when bit 33 of the note marks a read
   task automatic cmp_apb(input logic [33:0] exp);
      flag({exp[33], pslverr, exp[33] ? prdata : 32'h0}, exp);
   endtask

   task automatic cmp_exc(input logic [33:0] exp);
      flag({exceptionIsError, doubleFault, exceptionReturnAddr}, exp);
   endtask

   always @(posedge clk_sys) begin
      if (pready === 1'b1) cmp_apb(apbQ.size() ? apbQ.pop_front() : 'x);
      if (exceptionTaken === 1'b1) cmp_exc(excQ.size() ? excQ.pop_front() : 'x);
   end

   function automatic logic [33:0] status();
      return {2'b10, 32'(expHw) << hwexc_pkg::HW_CAUSE_LSB | 32'(expExc)};
   endfunction

   task automatic apb(input logic wr, input logic [11:0] a, input logic [33:0] exp);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wr ? exp[31:0] : $random(seed);
      apbQ.push_back(wr ? {2'b00 | exp[32], 32'h0} : exp);
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic hw_err(input logic [7:0] m, input logic [4:0] code);
      @(posedge clk_sys);
      start <= 1'b1;
      srcMask <= m;
      holdLen <= {1'b0, 3'($random(seed))} + 4'h1;
      expHw = code;
      @(posedge clk_sys);
      start <= 1'b0;
      repeat (12) @(posedge clk_sys);
      apb(1'b0, hwexc_pkg::SEQ_STATUS_OFFSET, status());
   endtask

   task automatic instr(input logic [4:0] fl, input logic frc, input logic [5:0] code,
         input logic isErr, input logic tk);
      logic [31:0] a;
      a = $random(seed);
      @(posedge clk_sys);
      instrFinishing <= 1'b1;
      instrFlags <= fl;
      forceException <= frc;
      forceExceptionImm <= code[3:0];
      instrAddr <= a;
      instrNextAddr <= a + 32'h4;
      if (tk) begin
         excQ.push_back({isErr, servicingCritical, (isErr | servicingCritical) ? a : a + 32'h4});
         expExc = code;
      end
      @(posedge clk_sys);
      instrFinishing <= 1'b0;
      instrFlags <= 5'h00;
      forceException <= 1'b0;
      repeat (2) @(posedge clk_sys);
      apb(1'b0, hwexc_pkg::SEQ_STATUS_OFFSET, status());
   endtask

   task automatic report_and_stop;
      if (apbQ.size() != 0 || excQ.size() != 0) nFail++;
      if (nFail == 0 && nCompared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      nFail++;
      report_and_stop();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      static logic [5:0] errCode [5] = '{6'h21, 6'h22, 6'h23, 6'h23, 6'h23};
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      apb(1'b0, 12'h000, status());
      apb(1'b1, 12'h000, {2'b01, 32'hffff_ffff});
      apb(1'b0, 12'h020, {2'b01, 32'h0});
      supervisorMode <= 1'b0;
      apb(1'b0, 12'h000, {2'b01, 32'h0});
      supervisorMode <= 1'b1;
      for (int s = 0; s < 8; s++) hw_err(8'h01 << s, hwexc_pkg::HW_SRC_CODE[s]);
      hw_err(8'h41, 5'h12);
      for (int k = 0; k < 5; k++) instr(5'h01 << k, 1'b0, errCode[k], 1'b1, 1'b1);
      instr(5'h00, 1'b1, {2'b00, 4'($random(seed))}, 1'b0, 1'b1);
      instr(5'h01, 1'b1, 6'h21, 1'b1, 1'b1);
      apb(1'b1, hwexc_pkg::EXC_CONTROL_OFFSET, {2'b00, 32'h1});
      instr(5'h00, 1'b0, 6'h10, 1'b0, 1'b1);
      apb(1'b1, hwexc_pkg::EXC_CONTROL_OFFSET, {2'b00, 32'h2});
      for (int t = 0; t < 2; t++) begin
         @(posedge clk_sys);
         traceBufferOverflow <= 1'b1;
         @(posedge clk_sys);
         traceBufferOverflow <= 1'b0;
         instr(5'h00, 1'b0, 6'h11, 1'b0, t == 0);
         apb(1'b1, hwexc_pkg::EXC_CONTROL_OFFSET, {2'b00, 32'h0});
      end
      servicingCritical <= 1'b1;
      instr(5'h02, 1'b0, 6'h22, 1'b1, 1'b1);
      instr(5'h00, 1'b1, 6'h05, 1'b0, 1'b1);
      servicingCritical <= 1'b0;
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      expHw = 5'h00;
      expExc = 6'h00;
      apb(1'b0, 12'h000, status());
      repeat (4) @(posedge clk_sys);
      report_and_stop();
   end
endmodule
